// *** hdl/pme_pkg.sv ***
// Shared constants, register map and carrier types of the packet mirror engine
package pme_pkg;
   localparam int NUM_SETS = 4;
   localparam int NUM_PORTS = 57;
   localparam int PORT_W = 6;
   localparam int DEV_W = 4;
   localparam int GROUP_W = 7;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int HASH_W = 8;
   localparam int MASK_HI_W = NUM_PORTS - DATA_W;
   // Word indices inside one set window, sets spaced by SET_STRIDE bytes
   localparam logic [ADDR_W-1:0] SET_STRIDE = 8'h20;
   localparam logic [2:0] WORD_CTRL = 3'h0;
   localparam logic [2:0] WORD_RX_LO = 3'h1;
   localparam logic [2:0] WORD_RX_HI = 3'h2;
   localparam logic [2:0] WORD_TX_LO = 3'h3;
   localparam logic [2:0] WORD_TX_HI = 3'h4;
   localparam logic [2:0] WORD_TAG_INS = 3'h5;
   localparam logic [2:0] WORD_TAG = 3'h6;
   localparam logic [2:0] WORD_STRIP = 3'h7;
   localparam logic [ADDR_W-1:0] COUNT_BASE = 8'h80;
   // Control word fields
   localparam int CTRL_DEV_LSB = 15;
   localparam int CTRL_PORT_LSB = 9;
   localparam int CTRL_GROUP_BIT = 8;
   localparam int CTRL_KIND_LSB = 0;
   // Remote tag word fields
   localparam int TAG_TPID_LSB = 16;
   localparam int TAG_PRI_LSB = 13;
   localparam int TAG_CFI_BIT = 12;
   localparam int TAG_VID_LSB = 0;

   typedef enum logic [1:0] {
      PME_KIND_OFF = 2'h0,
      PME_KIND_PORT = 2'h1,
      PME_KIND_REMOTE = 2'h2,
      PME_KIND_CLS = 2'h3
   } pme_set_kind_type;

   typedef struct packed {
      logic [15:0] tpid;
      logic [2:0] pri;
      logic cfi;
      logic [11:0] vid;
   } pme_tag_type;

   typedef struct packed {
      logic [DEV_W-1:0] analyzer_device_id;
      logic [PORT_W-1:0] analyzer_port_id;
      logic analyzer_is_group;
      pme_set_kind_type set_type;
      logic [NUM_PORTS-1:0] rx_mirror_mask;
      logic [NUM_PORTS-1:0] tx_mirror_mask;
      logic tag_insert;
      pme_tag_type remote_tag;
      logic remote_tag_strip;
   } pme_set_cfg_type;

   typedef struct packed {
      logic en;
      logic egress;
      logic [1:0] set_idx;
   } pme_cls_act_type;

   typedef struct packed {
      logic [PORT_W-1:0] src_port;
      logic mac_drop;
      logic ibw_drop;
      logic cpu_tx_tag;
      logic [NUM_PORTS-1:0] egr_mask;
      logic [NUM_PORTS-1:0] egr_drop;
      logic has_first_tag;
      logic [15:0] first_tpid;
      logic [11:0] first_vid;
      logic [HASH_W-1:0] hash;
      pme_cls_act_type vlan_classifier;
      pme_cls_act_type ingress_classifier;
   } pme_desc_type;

   typedef struct packed {
      logic egress;
      logic [PORT_W-1:0] egr_port;
      logic [DEV_W-1:0] analyzer_device_id;
      logic [PORT_W-1:0] analyzer_port_id;
      logic analyzer_is_group;
      logic [GROUP_W-1:0] group_id;
      logic [HASH_W-1:0] lb_hash;
      logic add_tag;
      pme_tag_type remote_tag;
      logic strip_tag;
      logic keep_cpu_tag;
   } pme_copy_type;
endpackage

// *** hdl/pme_hit_count.sv ***
// Per-set mirrored copy counters
`timescale 1ns/100ps
module pme_hit_count #(
   parameter int COUNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pme_pkg::NUM_SETS-1:0] fire,
   input wire logic [pme_pkg::NUM_SETS-1:0] clear,
   output logic [pme_pkg::NUM_SETS-1:0][COUNT_W-1:0] counts
);
   typedef struct packed {
      logic [pme_pkg::NUM_SETS-1:0][COUNT_W-1:0] cnt;
   } pme_cnt_state_type;

   pme_cnt_state_type state_reg;
   pme_cnt_state_type state_next;

   always_comb begin
      state_next = state_reg;
      for (int s = 0; s < pme_pkg::NUM_SETS; s++) begin
         // A copy in the clearing cycle still counts
         if (clear[s]) begin
            state_next.cnt[s] = COUNT_W'(fire[s]);
         end else if (fire[s]) begin
            state_next.cnt[s] = state_reg.cnt[s] + COUNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign counts = state_reg.cnt;
endmodule

// *** hdl/pme_regs.sv ***
// Avalon-MM register slave holding the four mirroring set configurations
`timescale 1ns/100ps
module pme_regs #(
   parameter int COUNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pme_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pme_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [pme_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [pme_pkg::NUM_SETS-1:0][COUNT_W-1:0] counts,
   output logic [pme_pkg::NUM_SETS-1:0] count_clear,
   output pme_pkg::pme_set_cfg_type [pme_pkg::NUM_SETS-1:0] cfg
);
   typedef struct packed {
      pme_pkg::pme_set_cfg_type [pme_pkg::NUM_SETS-1:0] cfg;
      logic ack;
      logic [pme_pkg::DATA_W-1:0] rdata;
   } pme_reg_state_type;

   pme_reg_state_type state_reg;
   pme_reg_state_type state_next;
   logic req;
   logic in_sets;
   logic in_counts;
   logic [1:0] set_sel;
   logic [2:0] word_sel;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction

   function automatic logic [31:0] read_word(input pme_pkg::pme_set_cfg_type c,
                                             input logic [2:0] w);
      logic [31:0] r;
      r = '0;
      case (w)
         pme_pkg::WORD_CTRL: begin
            r[pme_pkg::CTRL_DEV_LSB +: pme_pkg::DEV_W] = c.analyzer_device_id;
            r[pme_pkg::CTRL_PORT_LSB +: pme_pkg::PORT_W] = c.analyzer_port_id;
            r[pme_pkg::CTRL_GROUP_BIT] = c.analyzer_is_group;
            r[pme_pkg::CTRL_KIND_LSB +: 2] = c.set_type;
         end
         pme_pkg::WORD_RX_LO: r = c.rx_mirror_mask[31:0];
         pme_pkg::WORD_RX_HI: r[pme_pkg::MASK_HI_W-1:0] = c.rx_mirror_mask[56:32];
         pme_pkg::WORD_TX_LO: r = c.tx_mirror_mask[31:0];
         pme_pkg::WORD_TX_HI: r[pme_pkg::MASK_HI_W-1:0] = c.tx_mirror_mask[56:32];
         pme_pkg::WORD_TAG_INS: r[0] = c.tag_insert;
         pme_pkg::WORD_TAG: begin
            r[pme_pkg::TAG_TPID_LSB +: 16] = c.remote_tag.tpid;
            r[pme_pkg::TAG_PRI_LSB +: 3] = c.remote_tag.pri;
            r[pme_pkg::TAG_CFI_BIT] = c.remote_tag.cfi;
            r[pme_pkg::TAG_VID_LSB +: 12] = c.remote_tag.vid;
         end
         default: r[0] = c.remote_tag_strip;
      endcase
      read_word = r;
   endfunction

   assign req = avs_read | avs_write;
   assign in_sets = ~avs_address[7];
   assign in_counts = (avs_address[7:4] == pme_pkg::COUNT_BASE[7:4]);
   assign set_sel = in_sets ? avs_address[6:5] : avs_address[3:2];
   assign word_sel = avs_address[4:2];

   always_comb begin
      logic [31:0] w;
      w = '0;
      state_next = state_reg;
      state_next.ack = 1'b0;
      count_clear = '0;
      // One wait cycle, then the answer stands for the sampling edge
      if (req && !state_reg.ack) begin
         state_next.ack = 1'b1;
         state_next.rdata = '0;
         if (avs_read && in_sets) begin
            state_next.rdata = read_word(state_reg.cfg[set_sel], word_sel);
         end else if (avs_read && in_counts) begin
            state_next.rdata = 32'(counts[set_sel]);
         end
      end
      if (avs_write && state_reg.ack && in_counts) begin
         count_clear[set_sel] = 1'b1;
      end
      if (avs_write && state_reg.ack && in_sets) begin
         w = merge(read_word(state_reg.cfg[set_sel], word_sel), avs_writedata, avs_byteenable);
         case (word_sel)
            pme_pkg::WORD_CTRL: begin
               state_next.cfg[set_sel].analyzer_device_id = w[pme_pkg::CTRL_DEV_LSB +: 4];
               state_next.cfg[set_sel].analyzer_port_id = w[pme_pkg::CTRL_PORT_LSB +: 6];
               state_next.cfg[set_sel].analyzer_is_group = w[pme_pkg::CTRL_GROUP_BIT];
               state_next.cfg[set_sel].set_type =
                  pme_pkg::pme_set_kind_type'(w[pme_pkg::CTRL_KIND_LSB +: 2]);
            end
            pme_pkg::WORD_RX_LO: state_next.cfg[set_sel].rx_mirror_mask[31:0] = w;
            pme_pkg::WORD_RX_HI: state_next.cfg[set_sel].rx_mirror_mask[56:32] = w[24:0];
            pme_pkg::WORD_TX_LO: state_next.cfg[set_sel].tx_mirror_mask[31:0] = w;
            pme_pkg::WORD_TX_HI: state_next.cfg[set_sel].tx_mirror_mask[56:32] = w[24:0];
            pme_pkg::WORD_TAG_INS: state_next.cfg[set_sel].tag_insert = w[0];
            pme_pkg::WORD_TAG: begin
               state_next.cfg[set_sel].remote_tag.tpid = w[pme_pkg::TAG_TPID_LSB +: 16];
               state_next.cfg[set_sel].remote_tag.pri = w[pme_pkg::TAG_PRI_LSB +: 3];
               state_next.cfg[set_sel].remote_tag.cfi = w[pme_pkg::TAG_CFI_BIT];
               state_next.cfg[set_sel].remote_tag.vid = w[pme_pkg::TAG_VID_LSB +: 12];
            end
            default: state_next.cfg[set_sel].remote_tag_strip = w[0];
         endcase
      end
   end

   // All-zero reset leaves every set disabled
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_waitrequest = req & ~state_reg.ack;
   assign avs_readdata = state_reg.rdata;
   assign cfg = state_reg.cfg;
endmodule

// *** hdl/pme_packet_mirror_engine.sv ***
// Packet mirror engine: per-set mirror decision for each packet descriptor
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module pme_packet_mirror_engine #(
   parameter int HIT_COUNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pme_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pme_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [pme_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic desc_valid,
   input wire pme_pkg::pme_desc_type desc,
   output logic [pme_pkg::NUM_SETS-1:0] copy_valid,
   output pme_pkg::pme_copy_type [pme_pkg::NUM_SETS-1:0] copy_out
);
   if (HIT_COUNT_W < 1 || HIT_COUNT_W > pme_pkg::DATA_W) begin : g_bad_width
      $error("HIT_COUNT_W must lie between 1 and 32");
   end

   typedef struct packed {
      logic [pme_pkg::NUM_SETS-1:0] valid;
      pme_pkg::pme_copy_type [pme_pkg::NUM_SETS-1:0] copy;
   } pme_eng_state_type;

   pme_eng_state_type state_reg;
   pme_eng_state_type state_next;
   pme_pkg::pme_set_cfg_type [pme_pkg::NUM_SETS-1:0] cfg;
   logic [pme_pkg::NUM_SETS-1:0][HIT_COUNT_W-1:0] counts;
   logic [pme_pkg::NUM_SETS-1:0] count_clear;
   logic [pme_pkg::NUM_SETS-1:0][pme_pkg::NUM_PORTS-1:0] egr_live;

   pme_regs #(
      .COUNT_W(HIT_COUNT_W)
   ) u_regs (
      .core_clk(core_clk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .counts(counts),
      .count_clear(count_clear),
      .cfg(cfg)
   );

   pme_hit_count #(
      .COUNT_W(HIT_COUNT_W)
   ) u_count (
      .core_clk(core_clk),
      .rst(rst),
      .fire(state_reg.valid),
      .clear(count_clear),
      .counts(counts)
   );

   // Out-of-range port ids never hit a mask
   function automatic logic port_hit(input logic [pme_pkg::NUM_PORTS-1:0] mask,
                                     input logic [pme_pkg::PORT_W-1:0] idx);
      port_hit = 1'b0;
      for (int i = 0; i < pme_pkg::NUM_PORTS; i++) begin
         if (idx == pme_pkg::PORT_W'(i)) begin
            port_hit = mask[i];
         end
      end
   endfunction

   function automatic logic [pme_pkg::PORT_W-1:0] lowest_port(
         input logic [pme_pkg::NUM_PORTS-1:0] mask);
      lowest_port = '0;
      for (int i = pme_pkg::NUM_PORTS - 1; i >= 0; i--) begin
         if (mask[i]) begin
            lowest_port = pme_pkg::PORT_W'(i);
         end
      end
   endfunction

   function automatic logic names_set(input pme_pkg::pme_cls_act_type a,
                                      input int s);
      names_set = a.en && (a.set_idx == 2'(s));
   endfunction

   // Live egress ports: transmit mask hits not dropped on the way out
   always_comb begin
      for (int s = 0; s < pme_pkg::NUM_SETS; s++) begin
         egr_live[s] = cfg[s].tx_mirror_mask & desc.egr_mask & ~desc.egr_drop;
      end
   end

   always_comb begin
      logic ing_ok;
      logic is_remote_pkt;
      logic port_ing;
      logic port_egr;
      logic cls_ing;
      logic cls_egr;
      logic rem_hit;
      logic ing_hit;
      logic egr_hit;
      ing_ok = 1'b0;
      is_remote_pkt = 1'b0;
      port_ing = 1'b0;
      port_egr = 1'b0;
      cls_ing = 1'b0;
      cls_egr = 1'b0;
      rem_hit = 1'b0;
      ing_hit = 1'b0;
      egr_hit = 1'b0;
      state_next = state_reg;
      state_next.valid = '0;
      // VLAN ingress filter verdict is deliberately not an input
      ing_ok = !desc.mac_drop && !desc.ibw_drop;
      for (int s = 0; s < pme_pkg::NUM_SETS; s++) begin
         is_remote_pkt = desc.has_first_tag
                         && desc.first_tpid == cfg[s].remote_tag.tpid
                         && desc.first_vid == cfg[s].remote_tag.vid;
         port_ing = cfg[s].set_type == pme_pkg::PME_KIND_PORT && ing_ok
                    && port_hit(cfg[s].rx_mirror_mask, desc.src_port);
         port_egr = cfg[s].set_type == pme_pkg::PME_KIND_PORT && (|egr_live[s]);
         // VLAN classifier loses to the ingress classifier on the same set
         cls_ing = cfg[s].set_type == pme_pkg::PME_KIND_CLS && ing_ok
                   && ((names_set(desc.ingress_classifier, s)
                        && !desc.ingress_classifier.egress)
                       || (names_set(desc.vlan_classifier, s)
                           && !names_set(desc.ingress_classifier, s)));
         cls_egr = cfg[s].set_type == pme_pkg::PME_KIND_CLS
                   && names_set(desc.ingress_classifier, s)
                   && desc.ingress_classifier.egress
                   && (|egr_live[s]);
         rem_hit = cfg[s].set_type == pme_pkg::PME_KIND_REMOTE && ing_ok && is_remote_pkt
                   && port_hit(cfg[s].rx_mirror_mask, desc.src_port);
         ing_hit = port_ing || cls_ing || rem_hit;
         egr_hit = port_egr || cls_egr;
         // One copy per matched set, even toward the same analyzer
         state_next.valid[s] = desc_valid && (ing_hit || egr_hit);
         if (desc_valid && (ing_hit || egr_hit)) begin
            // Ingress wins when a port set hits both directions
            state_next.copy[s].egress = !ing_hit;
            state_next.copy[s].egr_port = ing_hit ? '0 : lowest_port(egr_live[s]);
            state_next.copy[s].analyzer_device_id = cfg[s].analyzer_device_id;
            state_next.copy[s].analyzer_port_id = cfg[s].analyzer_port_id;
            state_next.copy[s].analyzer_is_group = cfg[s].analyzer_is_group;
            state_next.copy[s].group_id = {cfg[s].analyzer_device_id[0],
                                           cfg[s].analyzer_port_id};
            // Hash goes along so the group port can balance members
            state_next.copy[s].lb_hash = desc.hash;
            state_next.copy[s].add_tag = cfg[s].tag_insert && !rem_hit
                                         && !is_remote_pkt;
            state_next.copy[s].remote_tag = cfg[s].remote_tag;
            state_next.copy[s].strip_tag = rem_hit && cfg[s].remote_tag_strip;
            state_next.copy[s].keep_cpu_tag = ing_hit && desc.cpu_tx_tag;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign copy_valid = state_reg.valid;
   assign copy_out = state_reg.copy;

   // Checks
   property p_off_set_silent;
      @(posedge core_clk) disable iff (rst)
         copy_valid[0] |-> $past(cfg[0].set_type) != pme_pkg::PME_KIND_OFF;
   endproperty
   a_off_set_silent: assert property (p_off_set_silent)
      else $error("disabled set produced a copy");

   property p_no_drop_ingress;
      @(posedge core_clk) disable iff (rst)
         copy_valid[0] && !copy_out[0].egress
         |-> !$past(desc.mac_drop) && !$past(desc.ibw_drop);
   endproperty
   a_no_drop_ingress: assert property (p_no_drop_ingress)
      else $error("ingress copy of a dropped packet");

   property p_lowest_egress;
      @(posedge core_clk) disable iff (rst)
         copy_valid[2] && copy_out[2].egress
         |-> (($past(egr_live[2]) & (57'h1 << copy_out[2].egr_port)) != '0)
             && (($past(egr_live[2]) & ((57'h1 << copy_out[2].egr_port) - 57'h1)) == '0);
   endproperty
   a_lowest_egress: assert property (p_lowest_egress)
      else $error("egress copy not from lowest live port");

   property p_group_id;
      @(posedge core_clk) disable iff (rst)
         copy_valid[0] |-> copy_out[0].group_id
                           == {$past(cfg[0].analyzer_device_id[0]),
                               $past(cfg[0].analyzer_port_id)};
   endproperty
   a_group_id: assert property (p_group_id)
      else $error("group id mismatch");

   property p_no_double_tag;
      @(posedge core_clk) disable iff (rst)
         copy_valid[2] && copy_out[2].add_tag
         |-> !($past(desc.has_first_tag)
               && $past(desc.first_tpid) == copy_out[2].remote_tag.tpid
               && $past(desc.first_vid) == copy_out[2].remote_tag.vid);
   endproperty
   a_no_double_tag: assert property (p_no_double_tag)
      else $error("remote tag added twice");

   property p_zero_mask_no_egress;
      @(posedge core_clk) disable iff (rst)
         desc_valid && cfg[3].set_type == pme_pkg::PME_KIND_CLS
         && cfg[3].tx_mirror_mask == '0 && !desc.vlan_classifier.en
         && !(desc.ingress_classifier.en && !desc.ingress_classifier.egress)
         |=> !copy_valid[3];
   endproperty
   a_zero_mask_no_egress: assert property (p_zero_mask_no_egress)
      else $error("egress classifier copy with empty transmit mask");

   property p_cpu_tag_kept;
      @(posedge core_clk) disable iff (rst)
         copy_valid[0] && !copy_out[0].egress
         |-> copy_out[0].keep_cpu_tag == $past(desc.cpu_tx_tag);
   endproperty
   a_cpu_tag_kept: assert property (p_cpu_tag_kept)
      else $error("processor tag handling wrong");

   property p_strip_remote_only;
      @(posedge core_clk) disable iff (rst)
         copy_valid[1] && copy_out[1].strip_tag
         |-> $past(cfg[1].set_type) == pme_pkg::PME_KIND_REMOTE
             && $past(cfg[1].remote_tag_strip);
   endproperty
   a_strip_remote_only: assert property (p_strip_remote_only)
      else $error("strip outside remote destination set");

   property p_icls_wins;
      @(posedge core_clk) disable iff (rst)
         desc_valid && cfg[2].set_type == pme_pkg::PME_KIND_CLS
         && desc.ingress_classifier.en && desc.ingress_classifier.egress
         && desc.ingress_classifier.set_idx == 2'h2
         && desc.vlan_classifier.en && desc.vlan_classifier.set_idx == 2'h2
         && (|egr_live[2])
         |=> copy_valid[2] && copy_out[2].egress;
   endproperty
   a_icls_wins: assert property (p_icls_wins)
      else $error("ingress classifier did not win");

   property p_each_set_copies;
      @(posedge core_clk) disable iff (rst)
         desc_valid && !desc.mac_drop && !desc.ibw_drop
         && cfg[0].set_type == pme_pkg::PME_KIND_PORT
         && cfg[1].set_type == pme_pkg::PME_KIND_PORT
         && port_hit(cfg[0].rx_mirror_mask, desc.src_port)
         && port_hit(cfg[1].rx_mirror_mask, desc.src_port)
         |=> copy_valid[0] && copy_valid[1] ##1 !copy_valid[0] || $past(desc_valid);
   endproperty
   a_each_set_copies: assert property (p_each_set_copies)
      else $error("matched sets did not each copy");

   property p_ingress_port_zero;
      @(posedge core_clk) disable iff (rst)
         copy_valid[0] && !copy_out[0].egress |-> copy_out[0].egr_port == '0;
   endproperty
   a_ingress_port_zero: assert property (p_ingress_port_zero)
      else $error("ingress copy carries an egress port");

   property p_cls_ignores_masks;
      @(posedge core_clk) disable iff (rst)
         desc_valid && cfg[3].set_type == pme_pkg::PME_KIND_CLS
         && !desc.mac_drop && !desc.ibw_drop
         && desc.ingress_classifier.en && !desc.ingress_classifier.egress
         && desc.ingress_classifier.set_idx == 2'h3
         |=> copy_valid[3] && !copy_out[3].egress;
   endproperty
   a_cls_ignores_masks: assert property (p_cls_ignores_masks)
      else $error("ingress classifier copy missing");

   // Classifier actions must not wake a set of another type
   property p_non_cls_set_silent;
      @(posedge core_clk) disable iff (rst)
         desc_valid && cfg[3].set_type != pme_pkg::PME_KIND_CLS
         && !port_hit(cfg[3].rx_mirror_mask, desc.src_port) && egr_live[3] == '0
         |=> !copy_valid[3];
   endproperty
   a_non_cls_set_silent: assert property (p_non_cls_set_silent)
      else $error("classifier action fired a non-classifier set");

   property p_tag_fields;
      @(posedge core_clk) disable iff (rst)
         copy_valid[2] |-> copy_out[2].remote_tag == $past(cfg[2].remote_tag);
   endproperty
   a_tag_fields: assert property (p_tag_fields)
      else $error("remote tag fields not taken from the tag word");

   property p_copy_one_cycle;
      @(posedge core_clk) disable iff (rst)
         copy_valid[2] && !desc_valid |=> !copy_valid[2];
   endproperty
   a_copy_one_cycle: assert property (p_copy_one_cycle)
      else $error("copy pulse longer than one descriptor");

   property p_drop_stops_all;
      @(posedge core_clk) disable iff (rst)
         desc_valid && (desc.mac_drop || desc.ibw_drop) && egr_live == '0
         |=> copy_valid == '0;
   endproperty
   a_drop_stops_all: assert property (p_drop_stops_all)
      else $error("dropped packet produced a copy");

   property p_egress_not_dropped;
      @(posedge core_clk) disable iff (rst)
         copy_valid[2] && copy_out[2].egress
         |-> ($past(desc.egr_drop) & (57'h1 << copy_out[2].egr_port)) == '0;
   endproperty
   a_egress_not_dropped: assert property (p_egress_not_dropped)
      else $error("egress copy of a dropped port");
endmodule

// *** verification/pme_analyzer.sv ***
// Analyzer stand-in at the mirror destination: tallies arriving copies
`timescale 1ns/100ps
module pme_analyzer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pme_pkg::NUM_SETS-1:0] copy_valid,
   output int n_copies
);
   // Every set pulse is a separate copy, even towards one port
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         n_copies <= 0;
      end else begin
         n_copies <= n_copies + $countones(copy_valid);
      end
   end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the packet mirror engine
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
   logic core_clk, rst, avs_read, avs_write, avs_waitrequest, desc_valid;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, copy_valid;
   pme_pkg::pme_desc_type desc, d;
   pme_pkg::pme_copy_type [3:0] copy_out;
   int n_errors = 0, check_count = 0, n_copies;
   pme_packet_mirror_engine pme_packet_mirror_engine_inst (.core_clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .desc_valid, .desc, .copy_valid, .copy_out);
   pme_analyzer pme_analyzer_inst (.core_clk, .rst, .copy_valid, .n_copies);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Waitrequest judged at the rising edge, as the slave itself sees it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] q);
      @(posedge core_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= wd;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] q;
      bus(1'b1, a, wd, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK("readdata", e, q)
   endtask
   task automatic send(input logic [3:0] e);
      @(posedge core_clk);
      desc <= d;
      desc_valid <= 1'b1;
      @(posedge core_clk);
      desc_valid <= 1'b0;
      @(negedge core_clk);
      `CHK("copy_valid", e, copy_valid)
   endtask
   task automatic t_reset;
      rd(8'h60, 32'h0);
      rd(8'hF0, 32'h0);
   endtask
   task automatic t_ingress;
      wr(8'h00, 32'h0002B201);
      rd(8'h00, 32'h0002B201);
      wr(8'h04, 32'h8);
      d = '0;
      d.src_port = 6'h03;
      send(4'h1);
      `CHK("port_id", 6'h19, copy_out[0].analyzer_port_id)
      `CHK("group_id", 7'h59, copy_out[0].group_id)
      `CHK("egress", 1'b0, copy_out[0].egress)
      d.mac_drop = 1'b1;
      send(4'h0);
      d.mac_drop = 1'b0;
      d.ibw_drop = 1'b1;
      send(4'h0);
   endtask
   task automatic t_multi;
      wr(8'h20, 32'h1);
      wr(8'h24, 32'h8);
      d = '0;
      d.src_port = 6'h03;
      send(4'h3);
      rd(8'h84, 32'h1);
   endtask
   task automatic t_egress;
      wr(8'h40, 32'h1);
      wr(8'h4C, 32'hE);
      d = '0;
      d.src_port = 6'h0A;
      d.egr_mask = 57'h0C;
      send(4'h4);
      `CHK("egr_port", 6'h02, copy_out[2].egr_port)
      `CHK("egress", 1'b1, copy_out[2].egress)
      wr(8'h54, 32'h1);
      wr(8'h58, 32'h81000064);
      send(4'h4);
      `CHK("add_tag", 1'b1, copy_out[2].add_tag)
      `CHK("tag_vid", 12'h064, copy_out[2].remote_tag.vid)
      d.has_first_tag = 1'b1;
      d.first_tpid = 16'h8100;
      d.first_vid = 12'h064;
      send(4'h4);
      `CHK("add_tag", 1'b0, copy_out[2].add_tag)
   endtask
   task automatic t_cls;
      wr(8'h60, 32'h1);
      d = '0;
      d.src_port = 6'h0A;
      d.ingress_classifier = '{1'b1, 1'b0, 2'h3};
      send(4'h0);
      wr(8'h60, 32'h3);
      send(4'h8);
      d.ingress_classifier.egress = 1'b1;
      d.egr_mask = 57'h10;
      send(4'h0);
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Whole run needs about eighty cycles; fifty times that is a hang
   initial begin
      repeat (4000) @(posedge core_clk);
      n_errors++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      desc_valid = 1'b0;
      desc = '0;
      d = '0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_ingress();
      t_multi();
      t_egress();
      t_cls();
      // Analyzer tallies a copy one edge after it stands
      repeat (2) @(negedge core_clk);
      `CHK("copies", 32'h7, n_copies)
      complete_run();
   end
endmodule
